//--- rtl/mcs_pkg.sv
// Package for the main converter startup sequencer: states, carriers, timing counts.
// Assumes a 25 MHz system clock and comparator results already made digital outside.
package mcs_pkg;

  // ==========================================================================
  // Clocks and timing
  localparam int unsigned SYS_CLK_HZ       = 25_000_000;
  localparam int unsigned SW_CLK_HZ        = 100_000;
  localparam int unsigned SW_DIV           = SYS_CLK_HZ / SW_CLK_HZ;
  localparam int unsigned PHASES           = 6;
  localparam int unsigned BOOT_START_CYC   = 8;
  localparam int unsigned BOOT_DROP_CYC    = 4;
  localparam int unsigned DROP_REFRESH_US  = 500;
  localparam int unsigned SOFTON_MS        = 100;
  localparam int unsigned SOFTON_STEPS     = 16;
  // Refresh interval and soft-on in switching cycles
  localparam int unsigned DROP_REFRESH_CYC = DROP_REFRESH_US * (SW_CLK_HZ / 1000) / 1000;
  localparam int unsigned SOFTON_CYC       = SOFTON_MS * (SW_CLK_HZ / 1000);
  localparam int unsigned SOFTON_STEP_CYC  = SOFTON_CYC / SOFTON_STEPS;
  // Minimum on-time in system clocks, within one switching period
  localparam int unsigned MIN_ON_CLK       = 10;
  localparam int unsigned CNT_W            = 16;

  // ==========================================================================
  // Phase drive encoding: each output is three-level
  typedef enum logic [1:0] {
    PH_MID  = 2'h0,
    PH_LOW  = 2'h1,
    PH_HIGH = 2'h2
  } mcs_phase_type;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_PREBIAS,
    ST_BOOT,
    ST_WAITCOMP,
    ST_SOFTSTART,
    ST_SOFTON,
    ST_RUN
  } mcs_state_type;

  // Comparator inputs from the analog side
  typedef struct packed {
    logic runRise;
    logic runFall;
    logic prebiasDone;
    logic compAboveOffset;
    logic ssAtClamp;
    logic lightLoad;
    logic auxUnder;
    logic auxOver;
    logic mainRegLow;
  } mcs_cmp_type;

endpackage

//--- rtl/mcs_boot_pulse.sv
// Boot-refresh pulse counter: counts low pulses on switching-cycle enables.
// Assumes swTick is a one-cycle pulse from the switching clock divider.
`timescale 1ns/1ns
module mcs_boot_pulse
  import mcs_pkg::*;
(
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  // Control
  input  wire logic             swTick,
  input  wire logic             start,
  input  wire logic [3:0]       pulseCount,
  // Status
  output logic                  busy,
  output logic                  done
);

  logic [3:0] cnt_q;
  logic       pend_q;

  // A start in mid-period waits for the next period boundary, so that every
  // counted window is a full minimum on-time and none is cut short
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_q <= 1'b0;
    end else if (start) begin
      pend_q <= 1'b1;
    end else if (swTick) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 4'h0;
    end else if (start) begin
      cnt_q <= pulseCount;
    end else if (swTick && !pend_q && cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      done <= 1'b0;
    end else begin
      done <= swTick && !pend_q && cnt_q == 4'h1 && !start;
    end
  end

  assign busy = (cnt_q != 4'h0) && !pend_q;

endmodule

//--- rtl/mcs_sequencer.sv
// Main converter startup sequencer: off state, soft-start, boot refresh, soft-on,
// phase dropping with periodic refresh, aux regulator power-good.
// Assumes analog comparators outside; their outputs are asynchronous and synchronised here.
`timescale 1ns/1ns
// Operation
// [R1] While run request is below its falling threshold, driver enable is low and phases sit mid-level.
// [R2] Run request above its rising threshold starts soft-start with prebias before the ramp.
// [R3] Driver enable goes high right after prebias completes.
// [R4] After driver enable, all phases are pulled low with minimum on-time for eight switching cycles.
// [R5] After boot refresh drivers stay enabled but idle until compensation exceeds the ramp offset.
// [R6] Soft-start complete is raised when the soft-start ramp reaches its clamp level.
// [R7] During soft-start switching is non-synchronous, low-side switches unused.
// [R8] After soft-start a soft-on period lengthens the synchronous on-time up to its limit.
// [R9] With dropping selected and light load, dropped phases lose high-side duty cycle by cycle.
// [R10] Once dropping settles the active phase count holds while load is unchanged.
// [R11] Dropped phases get four low minimum-on pulses at every refresh interval.
// [R12] The host finishes mode and fault configuration before raising run request.
// [R13] Aux power-good is pulled low outside its window, with hysteresis on both limits.
// [R14] Backup regulator re-enables when the main internal regulator falls below minimum.
// [R15] Run request falling at any point aborts the sequence back to the off state.
// [R16] Boot pulses and refresh interval are counted on the switching clock, one counter per event.
module mcs_sequencer
  import mcs_pkg::*;
(
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 arst_n,
  // Analog comparator inputs (asynchronous)
  input  wire mcs_cmp_type          cmpIn,
  // Configuration straps
  input  wire logic                 phaseDropSel,
  input  wire logic [2:0]           keepPhases,
  // Driver side
  output logic                      driver_enable_out,
  output mcs_phase_type [PHASES-1:0] phase_drive_outputs,
  output logic                      prebiasStart,
  output logic                      ssRampEnable,
  output logic                      softStartDone,
  output logic [CNT_W-1:0]          syncOnLevel,
  output logic [2:0]                activePhases,
  // Regulators
  output logic                      aux_regulator_good_o,
  output logic                      aux_regulator_good_oe,
  output logic                      backupRegEnable
);

  // ==========================================================================
  // Input synchronisers
  mcs_cmp_type meta_q;
  mcs_cmp_type cmp_q;
  logic        dropSel_meta_q;
  logic        dropSel_q;
  // Straps are static, but still settle through two flops after power-up
  logic [2:0]  keepMeta_q;
  logic [2:0]  keepSync_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q         <= '0;
      cmp_q          <= '0;
      dropSel_meta_q <= 1'b0;
      dropSel_q      <= 1'b0;
      keepMeta_q     <= 3'h0;
      keepSync_q     <= 3'h0;
    end else begin
      meta_q         <= cmpIn;
      cmp_q          <= meta_q;
      dropSel_meta_q <= phaseDropSel;
      dropSel_q      <= dropSel_meta_q;
      keepMeta_q     <= keepPhases;
      keepSync_q     <= keepMeta_q;
    end
  end

  // ==========================================================================
  // Switching clock divider and phase timing
  logic [7:0] div_q;
  logic       swTick;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 8'h00;
    end else if (div_q == 8'(SW_DIV - 1)) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  assign swTick = (div_q == 8'(SW_DIV - 1));

  // Minimum on-time window at the start of every switching period
  logic minOn;
  assign minOn = (div_q < 8'(MIN_ON_CLK));

  // ==========================================================================
  // Sequencer state
  mcs_state_type state_q;
  logic          bootStart;
  logic          bootBusy;
  logic          bootDone;
  logic          runOff;
  logic [CNT_W-1:0] softOnCnt_q;

  // Run request hysteresis: off below the falling threshold
  assign runOff = !cmp_q.runFall;  // see [R15]

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_OFF;
    end else if (runOff) begin
      state_q <= ST_OFF;  // see [R15]
    end else begin
      unique case (state_q)
        ST_OFF:       if (cmp_q.runRise) state_q <= ST_PREBIAS;  // see [R2]
        ST_PREBIAS:   if (cmp_q.prebiasDone) state_q <= ST_BOOT;
        ST_BOOT:      if (bootDone) state_q <= ST_WAITCOMP;
        ST_WAITCOMP:  if (cmp_q.compAboveOffset) state_q <= ST_SOFTSTART;  // see [R5]
        ST_SOFTSTART: if (cmp_q.ssAtClamp) state_q <= ST_SOFTON;  // see [R6]
        ST_SOFTON:    if (softOnCnt_q == CNT_W'(SOFTON_CYC)) state_q <= ST_RUN;  // see [R8]
        ST_RUN:       state_q <= ST_RUN;
      endcase
    end
  end

  // Pulse on entry to boot refresh
  assign bootStart = (state_q == ST_PREBIAS) && cmp_q.prebiasDone && !runOff;  // see [R4]

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      driver_enable_out <= 1'b0;
    end else begin
      driver_enable_out <= !runOff && state_q != ST_OFF
                           && !(state_q == ST_PREBIAS && !cmp_q.prebiasDone);  // see [R1] [R3]
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prebiasStart  <= 1'b0;
      ssRampEnable  <= 1'b0;
      softStartDone <= 1'b0;
    end else begin
      prebiasStart  <= !runOff && state_q == ST_PREBIAS;  // see [R2]
      ssRampEnable  <= !runOff && state_q inside {ST_BOOT, ST_WAITCOMP, ST_SOFTSTART};
      softStartDone <= !runOff && (state_q inside {ST_SOFTON, ST_RUN}
                       || (state_q == ST_SOFTSTART && cmp_q.ssAtClamp));  // see [R6]
    end
  end

  // ==========================================================================
  // Soft-on: synchronous on-time grows step by step
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      softOnCnt_q <= '0;
    end else if (state_q != ST_SOFTON) begin
      softOnCnt_q <= '0;
    end else if (swTick && softOnCnt_q != CNT_W'(SOFTON_CYC)) begin
      softOnCnt_q <= softOnCnt_q + CNT_W'(1);  // see [R8]
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      syncOnLevel <= '0;
    end else if (runOff) begin
      syncOnLevel <= '0;  // see [R15]
    end else if (state_q == ST_SOFTON) begin
      syncOnLevel <= CNT_W'(softOnCnt_q / CNT_W'(SOFTON_STEP_CYC));  // see [R8]
    end else if (state_q == ST_RUN) begin
      syncOnLevel <= CNT_W'(SOFTON_STEPS);
    end else begin
      syncOnLevel <= '0;  // see [R7]
    end
  end

  // Low side conducts for a growing share of the off half-period; level 0 stays
  // non-synchronous, full level matches steady synchronous switching
  logic [7:0] offPos;
  logic       syncOn;

  assign offPos = div_q - 8'(SW_DIV / 2);
  assign syncOn = (CNT_W'(offPos) * CNT_W'(SOFTON_STEPS)) < (syncOnLevel * CNT_W'(SW_DIV / 2));

  // ==========================================================================
  // Phase dropping: high-side duty of dropped phases shrinks cycle by cycle
  logic [7:0] dropDuty_q;
  logic       dropping;

  assign dropping = !runOff && state_q == ST_RUN && dropSel_q && cmp_q.lightLoad;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dropDuty_q <= 8'(SW_DIV / 2);
    end else if (!dropping) begin
      dropDuty_q <= 8'(SW_DIV / 2);
    end else if (swTick && dropDuty_q != 8'h00) begin
      dropDuty_q <= dropDuty_q - 8'h01;  // see [R9]
    end
  end

  // Count only changes with the dropping condition: run state, dropping selected and light load
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      activePhases <= 3'(PHASES);
    end else if (dropping && dropDuty_q == 8'h00) begin
      activePhases <= keepSync_q;  // see [R10]
    end else if (!dropping) begin
      activePhases <= 3'(PHASES);
    end
  end

  logic dropSettled;
  assign dropSettled = dropping && dropDuty_q == 8'h00;

  // ==========================================================================
  // Refresh interval for dropped phases
  logic [CNT_W-1:0] refCnt_q;
  logic             refStart;
  logic             dropBusy;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      refCnt_q <= '0;
    end else if (!dropSettled) begin
      refCnt_q <= '0;
    end else if (swTick) begin
      refCnt_q <= (refCnt_q == CNT_W'(DROP_REFRESH_CYC - 1)) ? '0 : refCnt_q + CNT_W'(1);
    end
  end

  assign refStart = dropSettled && swTick && refCnt_q == CNT_W'(DROP_REFRESH_CYC - 1);  // see [R11]

  // One pulse counter for each refresh event, so a dropped-phase refresh can never
  // inherit a count left over from the start-up burst
  mcs_boot_pulse u_boot_start (  // see [R16]
    .sys_clk    (sys_clk),
    .arst_n     (arst_n),
    .swTick     (swTick),
    .start      (bootStart),
    .pulseCount (4'(BOOT_START_CYC)),
    .busy       (bootBusy),
    .done       (bootDone)
  );

  mcs_boot_pulse u_boot_drop (  // see [R16]
    .sys_clk    (sys_clk),
    .arst_n     (arst_n),
    .swTick     (swTick),
    .start      (refStart),
    .pulseCount (4'(BOOT_DROP_CYC)),
    .busy       (dropBusy),
    .done       ()
  );

  // ==========================================================================
  // Phase outputs
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_drive_outputs <= '{default: PH_MID};
    end else begin
      for (int i = 0; i < PHASES; i++) begin
        if (runOff || state_q inside {ST_OFF, ST_PREBIAS, ST_WAITCOMP}) begin
          phase_drive_outputs[i] <= PH_MID;  // see [R1] [R5]
        end else if (state_q == ST_BOOT) begin
          phase_drive_outputs[i] <= (bootBusy && minOn) ? PH_LOW : PH_MID;  // see [R4]
        end else if (dropSettled && i >= int'(keepSync_q)) begin
          phase_drive_outputs[i] <= (dropBusy && minOn) ? PH_LOW : PH_MID;  // see [R11]
        end else if (dropping && i >= int'(keepSync_q)) begin
          phase_drive_outputs[i] <= (div_q < dropDuty_q) ? PH_HIGH : PH_MID;  // see [R9]
        end else if (div_q < 8'(SW_DIV / 2)) begin
          phase_drive_outputs[i] <= PH_HIGH;
        end else if (state_q == ST_SOFTSTART) begin
          // Non-synchronous in soft-start: off phase is mid, low side unused
          phase_drive_outputs[i] <= PH_MID;  // see [R7]
        end else if (state_q == ST_SOFTON) begin
          phase_drive_outputs[i] <= syncOn ? PH_LOW : PH_MID;  // see [R8]
        end else begin
          phase_drive_outputs[i] <= PH_LOW;
        end
      end
    end
  end

  // ==========================================================================
  // Aux regulator power-good; hysteresis is left to the analog comparators, their outputs are only synchronised here
  logic auxGood_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      auxGood_q <= 1'b0;
    end else begin
      auxGood_q <= !cmp_q.auxUnder && !cmp_q.auxOver;  // see [R13]
    end
  end

  // Open drain: only ever drives low
  assign aux_regulator_good_o  = 1'b0;
  assign aux_regulator_good_oe = !auxGood_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      backupRegEnable <= 1'b1;
    end else begin
      backupRegEnable <= cmp_q.mainRegLow;  // see [R14]
    end
  end

endmodule

//--- sim/mcs_sequencer_chk.sv
// Checker for the startup sequencer: timing relations seen at its ports.
// Assumes comparator changes reach the outputs three clock edges later.
`timescale 1ns/1ns
module mcs_sequencer_chk
  import mcs_pkg::*;
(
  // Clock and reset
  input wire logic                       sys_clk,
  input wire logic                       arst_n,
  // Observed ports
  input wire mcs_cmp_type                cmpIn,
  input wire logic                       driver_enable_out,
  input wire mcs_phase_type [PHASES-1:0] phase_drive_outputs,
  input wire logic                       prebiasStart,
  input wire logic                       softStartDone,
  input wire logic [CNT_W-1:0]           syncOnLevel,
  input wire logic [2:0]                 activePhases,
  input wire logic                       aux_regulator_good_o,
  input wire logic                       aux_regulator_good_oe,
  input wire logic                       backupRegEnable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // ==========
  // Helpers
  logic       allMid;
  logic       low0;
  logic       offOut;
  logic       fullPulse;
  logic       syncOk;
  logic [7:0] lowRun_q;
  assign allMid    = (phase_drive_outputs == {PHASES{PH_MID}});
  assign low0      = (phase_drive_outputs[0] == PH_LOW);
  assign offOut    = !driver_enable_out && allMid && !prebiasStart;
  assign fullPulse = (lowRun_q == 8'(MIN_ON_CLK));
  assign syncOk    = softStartDone && syncOnLevel <= CNT_W'(SOFTON_STEPS);
  // Wraps harmlessly after soft-start, where the pulse check is off
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) lowRun_q <= 8'h00;
    else lowRun_q <= low0 ? lowRun_q + 8'h01 : 8'h00;
  end
  sequence runLow; !cmpIn.runFall [*4]; endsequence
  sequence auxOk; (!cmpIn.auxUnder && !cmpIn.auxOver) [*4]; endsequence
  sequence auxBad; (cmpIn.auxUnder || cmpIn.auxOver) [*4]; endsequence
  // ==========
  // Assertions
  a_off_state: assert property (runLow |-> offOut)
    else $error("sequencer not off while run request low");
  a_idle_mid: assert property (!driver_enable_out |-> allMid)
    else $error("phase driven while drivers disabled");
  a_enable_after_prebias: assert property ($rose(driver_enable_out) |-> prebiasStart)
    else $error("driver enable rose outside prebias");
  a_boot_min_on: assert property ($fell(low0) && !softStartDone |-> fullPulse)
    else $error("low pulse not minimum on-time");
  a_done_at_clamp: assert property ($rose(softStartDone) |-> $past(cmpIn.ssAtClamp, 2))
    else $error("soft-start done without clamp");
  a_sync_after_ss: assert property (syncOnLevel != 0 |-> syncOk)
    else $error("synchronous on-time during soft-start");
  a_full_phases: assert property (!softStartDone |-> activePhases == 3'h6)
    else $error("phase dropped before soft-on");
  a_aux_good: assert property (auxOk |-> !aux_regulator_good_oe)
    else $error("power-good low inside window");
  a_aux_bad: assert property (auxBad |-> aux_regulator_good_oe && !aux_regulator_good_o)
    else $error("power-good not pulled low");
  a_backup_on: assert property (cmpIn.mainRegLow [*4] |-> backupRegEnable)
    else $error("backup regulator not enabled");
  a_backup_off: assert property (!cmpIn.mainRegLow [*4] |-> !backupRegEnable)
    else $error("backup regulator left on");
endmodule

bind mcs_sequencer mcs_sequencer_chk u_chk (.sys_clk, .arst_n, .cmpIn, .driver_enable_out,
  .phase_drive_outputs, .prebiasStart, .softStartDone, .syncOnLevel, .activePhases,
  .aux_regulator_good_o, .aux_regulator_good_oe, .backupRegEnable);

//--- sim/mcs_fet_driver_model.sv
// Model of the external half-bridge drivers: gate states and pulse counts.
// Assumes the testbench clears the counts between measurements.
`timescale 1ns/1ns
module mcs_fet_driver_model
  import mcs_pkg::*;
(
  // Clock and control
  input  wire logic                       sys_clk,
  input  wire logic                       clr,
  // Controller side
  input  wire logic                       driver_enable_out,
  input  wire mcs_phase_type [PHASES-1:0] phase_drive_outputs,
  // Gate states and counts
  output logic [PHASES-1:0]               hsOn,
  output logic [PHASES-1:0]               lsOn,
  output int                              lowEdges,
  output int                              lowClocks,
  output int                              highClocks
);
  mcs_phase_type [PHASES-1:0] prev;
  // ==========
  // Mid level or a disabled driver leaves both switches off
  always_comb begin
    for (int i = 0; i < PHASES; i++) begin
      hsOn[i] = driver_enable_out && phase_drive_outputs[i] == PH_HIGH;
      lsOn[i] = driver_enable_out && phase_drive_outputs[i] == PH_LOW;
    end
  end
  always @(posedge sys_clk) begin
    if (clr) begin
      lowEdges = 0;
      lowClocks = 0;
      highClocks = 0;
    end else begin
      for (int i = 0; i < PHASES; i++) begin
        lowClocks += lsOn[i];
        highClocks += hsOn[i];
        lowEdges += (lsOn[i] && prev[i] != PH_LOW);
      end
    end
    prev = phase_drive_outputs;
  end
endmodule

//--- sim/test_mcs_sequencer.sv
// Self-checking bench for the startup sequencer with a driver model.
// Assumes the checker is bound through its own file.
`timescale 1ns/1ns
module test_mcs_sequencer;
  import mcs_pkg::*;
  logic                       sys_clk, arst_n, phaseDropSel, clr;
  logic                       drvEn, prebias, ramp, ssDone, auxO, auxOe, backup;
  logic [2:0]                 keepPhases, activePhases;
  logic [CNT_W-1:0]           syncLvl;
  logic [PHASES-1:0]          hsOn, lsOn;
  mcs_cmp_type                cmp;
  mcs_phase_type [PHASES-1:0] ph;
  int                         lowEdges, lowClocks, highClocks, fail_count, n_compared, w;

  mcs_sequencer dut (.sys_clk, .arst_n, .cmpIn(cmp), .phaseDropSel, .keepPhases,
    .driver_enable_out(drvEn), .phase_drive_outputs(ph), .prebiasStart(prebias),
    .ssRampEnable(ramp), .softStartDone(ssDone), .syncOnLevel(syncLvl), .activePhases,
    .aux_regulator_good_o(auxO), .aux_regulator_good_oe(auxOe), .backupRegEnable(backup));
  mcs_fet_driver_model drv (.sys_clk, .clr, .driver_enable_out(drvEn),
    .phase_drive_outputs(ph), .hsOn, .lsOn, .lowEdges, .lowClocks, .highClocks);

  // ==========
  // Shared tasks
  task automatic chk(input bit ok, input string msg);
    n_compared++;
    if (!ok) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  // Inputs always change 2 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task automatic wait_for(ref logic s, input int lim);
    w = 0;
    while (s !== 1'b1 && w < lim) begin
      tick(1);
      w++;
    end
  endtask
  task automatic give_verdict;
    $display("Compared %0d, failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========
  // Scenarios
  task automatic t_off;
    tick(4);
    chk(drvEn === 1'b0 && ph === {PHASES{PH_MID}}, "driver not off");
    chk(hsOn === '0 && lsOn === '0 && activePhases === 3'h6, "idle state");
    $display("test off done");
  endtask
  task automatic t_start;
    cmp.runFall = 1;
    cmp.runRise = 1;
    wait_for(prebias, 8);
    chk(w < 8, "no prebias");
    tick(6);
    chk(drvEn === 1'b0 && ramp === 1'b0, "early enable or ramp");
    cmp.prebiasDone = 1;
    clr = 1;
    wait_for(drvEn, 6);
    clr = 0;
    chk(w == 3, "driver enable latency");
    $display("test start done");
  endtask
  task automatic t_boot;
    tick(BOOT_START_CYC * SW_DIV + 400);
    chk(lowEdges == BOOT_START_CYC * PHASES, "boot pulse count");
    chk(lowClocks == BOOT_START_CYC * PHASES * MIN_ON_CLK, "boot on-time");
    chk(highClocks == 0 && drvEn === 1'b1, "switching before comp");
    clr = 1;
    cmp.compAboveOffset = 1;
    tick(1);
    clr = 0;
    tick(2 * SW_DIV);
    chk(highClocks > 0 && lowClocks == 0, "non-sync switching");
    $display("test boot done");
  endtask
  task automatic t_ss;
    cmp.lightLoad = 1;
    chk(ssDone === 1'b0 && syncLvl === '0, "done early");
    cmp.ssAtClamp = 1;
    wait_for(ssDone, 6);
    chk(w == 3, "soft-start done latency");
    clr = 1;
    tick(1);
    clr = 0;
    tick(SW_DIV);
    chk(drvEn === 1'b1 && activePhases === 3'h6, "soft-on state");
    chk(syncLvl === '0 && lowClocks == 0 && highClocks > 0, "soft-on start");
    $display("test soft-start done");
  endtask
  task automatic t_abort;
    cmp = '0;
    tick(3);
    chk(drvEn === 1'b0 && ph === {PHASES{PH_MID}} && ssDone === 1'b0, "abort");
    tick(4);
    cmp.runFall = 1;
    cmp.runRise = 1;
    wait_for(prebias, 8);
    cmp = '0;
    tick(4);
    chk(prebias === 1'b0 && drvEn === 1'b0, "abort in prebias");
    $display("test abort done");
  endtask
  task automatic t_aux;
    for (int i = 0; i < 4; i++) begin
      cmp.auxUnder = i[0];
      cmp.auxOver = i[1];
      cmp.mainRegLow = i[0];
      tick(4);
      chk(auxOe === (i != 0) && auxO === 1'b0, "aux power-good");
      chk(backup === i[0], "backup regulator");
    end
    $display("test aux done");
  endtask

  // ==========
  // Clock, sequence and watchdog
  initial begin
    sys_clk = 0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    arst_n = 0;
    cmp = '0;
    // Mode straps settle long before the run request rises
    phaseDropSel = 1;
    keepPhases = 3'h3;
    clr = 0;
    fail_count = 0;
    n_compared = 0;
    repeat (5) @(posedge sys_clk);
    #2;
    arst_n = 1;
    t_off;
    t_start;
    t_boot;
    t_ss;
    t_abort;
    t_aux;
    give_verdict;
  end
  // Whole run needs about 3200 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    give_verdict;
  end
endmodule
